// file: rtl/afmc_consts.vh
// Constants of the filter and input multiplexer configuration block.
`ifndef AFMC_CONSTS_VH
`define AFMC_CONSTS_VH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define AFMC_IDX_ECG 6'h15
`define AFMC_IDX_BMUX 6'h17
`define AFMC_IDX_AUX 6'h1f

// ****************************************************************
// Writable masks and reset values.
// ****************************************************************
`define AFMC_ECG_MASK 24'hc03000
`define AFMC_ECG_RESET 24'h801000
`define AFMC_BMUX_MASK 24'h3f3f73
`define AFMC_BMUX_RESET 24'h300040
`define AFMC_AUX_MASK 24'h00001f
`define AFMC_AUX_RESET 24'h000000

// ****************************************************************
// Field positions.
// ****************************************************************
`define AFMC_ECG_SAMPLE_RATE_SELECT_LSB 22
`define AFMC_ECG_LPF_LSB 12
`define AFMC_POS_ISO_BIT 21
`define AFMC_NEG_ISO_BIT 20
`define AFMC_POS_CAL_LSB 18
`define AFMC_NEG_CAL_LSB 16
`define AFMC_CG_MODE_LSB 12
`define AFMC_BIST_EN_BIT 11
`define AFMC_RNOM_LSB 8
`define AFMC_RMOD_LSB 4
`define AFMC_FBIST_LSB 0
`define AFMC_AUX_MCLK_LSB 0
`define AFMC_AUX_VCAL_BIT 2
`define AFMC_AUX_HIRANGE_BIT 3
`define AFMC_AUX_HIRES_BIT 4

// ****************************************************************
// Cutoff classes of the low-pass filter.
// ****************************************************************
`define AFMC_CUT_BYPASS 3'h0
`define AFMC_CUT_40 3'h1
`define AFMC_CUT_100 3'h2
`define AFMC_CUT_150 3'h3
`define AFMC_CUT_LOW 3'h4

// ****************************************************************
// Self-test divider width, for the largest division 2^19.
// ****************************************************************
`define AFMC_DIV_BITS 19

`endif

// file: rtl/afmc_lpf_map.v
// Mapping of the written low-pass code to the applied code and cutoff.
`include "afmc_consts.vh"

module afmc_lpf_map (
  // Settings
  input wire [1:0] master_clock_select,
  input wire [1:0] ecg_sample_rate_select,
  input wire [1:0] ecg_lowpass_select,
  // Applied settings
  output reg [1:0] lpf_eff,
  output reg [2:0] lpf_cut
);

  always @* begin
    lpf_eff = 2'h1;
    lpf_cut = `AFMC_CUT_40;
    if (ecg_lowpass_select == 2'h0) begin
      lpf_eff = 2'h0;
      lpf_cut = `AFMC_CUT_BYPASS;
    end else if (master_clock_select[1]) begin
      lpf_eff = 2'h1;
      lpf_cut = `AFMC_CUT_40;
    end else if (ecg_sample_rate_select == 2'h2) begin
      lpf_eff = 2'h1;
      lpf_cut = `AFMC_CUT_LOW;
    end else if (ecg_sample_rate_select == 2'h3) begin
      lpf_eff = 2'h1;
      lpf_cut = `AFMC_CUT_40;
    end else if (ecg_lowpass_select == 2'h2) begin
      lpf_eff = 2'h2;
      lpf_cut = `AFMC_CUT_100;
    end else if (ecg_lowpass_select == 2'h3 &&
                 ecg_sample_rate_select == 2'h0) begin
      lpf_eff = 2'h3;
      lpf_cut = `AFMC_CUT_150;
    end else begin
      lpf_eff = 2'h1;
      lpf_cut = `AFMC_CUT_40;
    end
  end

endmodule

// file: rtl/afmc_bist_div.v
// Self-test modulation square wave divided from master clock ticks.
`include "afmc_consts.vh"

module afmc_bist_div (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Control
  input wire run,
  input wire mclk_tick,
  input wire [1:0] freq_sel,
  // Square wave
  output reg square_ff
);

  reg [`AFMC_DIV_BITS-1:0] cnt_ff;
  reg [`AFMC_DIV_BITS-1:0] nxt_cnt;
  reg nxt_square;

  always @* begin
    nxt_cnt = cnt_ff;
    if (!run) begin
      nxt_cnt = {`AFMC_DIV_BITS{1'b0}};
    end else if (mclk_tick) begin
      nxt_cnt = cnt_ff + {{(`AFMC_DIV_BITS-1){1'b0}}, 1'b1};
    end
    case (freq_sel)
      2'h0: nxt_square = nxt_cnt[12];
      2'h1: nxt_square = nxt_cnt[14];
      2'h2: nxt_square = nxt_cnt[16];
      default: nxt_square = nxt_cnt[18];
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= {`AFMC_DIV_BITS{1'b0}};
      square_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      square_ff <= nxt_square;
    end
  end

endmodule

// file: rtl/afmc_top.v
// Register bank for the ECG low-pass select and the bioimpedance input mux.
`include "afmc_consts.vh"

module afmc_top (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Avalon-MM slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata_ff,
  output reg avs_waitrequest_ff,
  // Master clock tick, one cycle per master clock period
  input wire mclk_tick,
  // ECG filter settings as applied
  output reg [1:0] ecg_lowpass_eff_ff,
  output reg [2:0] ecg_lowpass_cutoff_ff,
  // Bioimpedance input switches
  output reg bioz_pos_input_connect_ff,
  output reg bioz_neg_input_connect_ff,
  // Calibration routing, one-hot or all zero: mid-supply, positive, negative source
  output reg [2:0] bioz_pos_route_ff,
  output reg [2:0] bioz_neg_route_ff,
  // Current generator controls
  output reg cg_chop_ff,
  output reg cg_lowpass_ff,
  output reg cg_resistive_cm_ff,
  // Self-test controls
  output reg drive_outputs_isolate_ff,
  output reg drive_to_input_close_ff,
  output reg lead_bias_200m_ff,
  output reg [2:0] selftest_nominal_res_ff,
  output reg [2:0] modulation_switches_ff
);

  // ****************************************************************
  // Byte-lane merge of a write into a 24-bit register.
  // ****************************************************************
  function [23:0] be_merge;
    input [23:0] old;
    input [31:0] wdata;
    input [3:0] be;
    input [23:0] mask;
    reg [23:0] lanes;
    begin
      lanes = {{8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      be_merge = ((old & ~lanes) | (wdata[23:0] & lanes)) & mask;
    end
  endfunction

  // ****************************************************************
  // Register state.
  // ****************************************************************
  reg [23:0] ecg_cfg_ff;
  reg [23:0] bmux_cfg_ff;
  reg [23:0] aux_cfg_ff;
  reg [23:0] nxt_ecg_cfg;
  reg [23:0] nxt_bmux_cfg;
  reg [23:0] nxt_aux_cfg;
  reg [31:0] nxt_readdata;
  reg nxt_waitrequest;

  wire [1:0] master_clock_select;
  wire [1:0] ecg_sample_rate_select;
  wire [1:0] ecg_lowpass_select;
  wire cal_voltage_enable;
  wire drive_range_select;
  wire high_res_selftest;
  wire bioz_pos_input_isolate;
  wire bioz_neg_input_isolate;
  wire [1:0] bioz_pos_cal_route;
  wire [1:0] bioz_neg_cal_route;
  wire [1:0] current_gen_mode;
  wire resistance_selftest_enable;
  wire [2:0] selftest_nominal_res;
  wire [2:0] selftest_modulation_sel;
  wire [1:0] selftest_freq_sel;

  assign master_clock_select =
    aux_cfg_ff[`AFMC_AUX_MCLK_LSB+1:`AFMC_AUX_MCLK_LSB];
  assign cal_voltage_enable = aux_cfg_ff[`AFMC_AUX_VCAL_BIT];
  assign drive_range_select = aux_cfg_ff[`AFMC_AUX_HIRANGE_BIT];
  assign high_res_selftest = aux_cfg_ff[`AFMC_AUX_HIRES_BIT];
  assign ecg_sample_rate_select =
    ecg_cfg_ff[`AFMC_ECG_SAMPLE_RATE_SELECT_LSB+1:`AFMC_ECG_SAMPLE_RATE_SELECT_LSB];
  assign ecg_lowpass_select =
    ecg_cfg_ff[`AFMC_ECG_LPF_LSB+1:`AFMC_ECG_LPF_LSB];
  assign bioz_pos_input_isolate = bmux_cfg_ff[`AFMC_POS_ISO_BIT];
  assign bioz_neg_input_isolate = bmux_cfg_ff[`AFMC_NEG_ISO_BIT];
  assign bioz_pos_cal_route =
    bmux_cfg_ff[`AFMC_POS_CAL_LSB+1:`AFMC_POS_CAL_LSB];
  assign bioz_neg_cal_route =
    bmux_cfg_ff[`AFMC_NEG_CAL_LSB+1:`AFMC_NEG_CAL_LSB];
  assign current_gen_mode =
    bmux_cfg_ff[`AFMC_CG_MODE_LSB+1:`AFMC_CG_MODE_LSB];
  assign resistance_selftest_enable = bmux_cfg_ff[`AFMC_BIST_EN_BIT];
  assign selftest_nominal_res =
    bmux_cfg_ff[`AFMC_RNOM_LSB+2:`AFMC_RNOM_LSB];
  assign selftest_modulation_sel =
    bmux_cfg_ff[`AFMC_RMOD_LSB+2:`AFMC_RMOD_LSB];
  assign selftest_freq_sel =
    bmux_cfg_ff[`AFMC_FBIST_LSB+1:`AFMC_FBIST_LSB];

  // ****************************************************************
  // Applied low-pass setting.
  // ****************************************************************
  wire [1:0] lpf_eff;
  wire [2:0] lpf_cut;

  afmc_lpf_map u_lpf_map (
    .master_clock_select(master_clock_select),
    .ecg_sample_rate_select(ecg_sample_rate_select),
    .ecg_lowpass_select(ecg_lowpass_select),
    .lpf_eff(lpf_eff),
    .lpf_cut(lpf_cut)
  );

  // ****************************************************************
  // Self-test modulation.
  // ****************************************************************
  wire bist_active;
  wire mod_run;
  wire square;

  assign bist_active = resistance_selftest_enable &
                       ~cal_voltage_enable;
  assign mod_run = bist_active & ~high_res_selftest;

  afmc_bist_div u_bist_div (
    .clk(clk),
    .resetn(resetn),
    .run(mod_run),
    .mclk_tick(mclk_tick),
    .freq_sel(selftest_freq_sel),
    .square_ff(square)
  );

  // ****************************************************************
  // Modulation switch decode.
  // ****************************************************************
  function [2:0] mod_dec;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: mod_dec = 3'h1;
        3'h1: mod_dec = 3'h2;
        3'h2: mod_dec = 3'h4;
        default: mod_dec = 3'h0;
      endcase
    end
  endfunction

  reg [2:0] nxt_mod_sw;

  always @* begin
    nxt_mod_sw = 3'h0;
    if (mod_run && square) begin
      nxt_mod_sw = mod_dec(selftest_modulation_sel);
    end
  end

  // ****************************************************************
  // Calibration routing.
  // ****************************************************************
  function [2:0] route_dec;
    input [1:0] sel;
    input vcal;
    begin
      case (sel)
        2'h1: route_dec = 3'h1;
        2'h2: route_dec = vcal ? 3'h2 : 3'h0;
        2'h3: route_dec = vcal ? 3'h4 : 3'h0;
        default: route_dec = 3'h0;
      endcase
    end
  endfunction

  // ****************************************************************
  // Address decode of one aligned register word.
  // ****************************************************************
  function reg_hit;
    input [7:0] addr;
    input [5:0] idx;
    begin
      reg_hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
    end
  endfunction

  // ****************************************************************
  // Avalon-MM slave: waitrequest drops one cycle after the request.
  // ****************************************************************
  wire req;
  wire hit_ecg;
  wire hit_bmux;
  wire hit_aux;
  wire commit;
  wire [23:0] ecg_read;

  assign req = avs_read | avs_write;
  assign hit_ecg = reg_hit(avs_address, `AFMC_IDX_ECG);
  assign hit_bmux = reg_hit(avs_address, `AFMC_IDX_BMUX);
  assign hit_aux = reg_hit(avs_address, `AFMC_IDX_AUX);
  assign commit = avs_write & ~avs_waitrequest_ff;
  assign ecg_read = (ecg_cfg_ff & ~(24'h3 << `AFMC_ECG_LPF_LSB)) |
                    ({22'h0, lpf_eff} << `AFMC_ECG_LPF_LSB);

  always @* begin
    nxt_waitrequest = 1'b1;
    if (req && avs_waitrequest_ff) begin
      nxt_waitrequest = 1'b0;
    end
    nxt_readdata = avs_readdata_ff;
    if (avs_read && avs_waitrequest_ff) begin
      if (hit_ecg) begin
        nxt_readdata = {8'h0, ecg_read};
      end else if (hit_bmux) begin
        nxt_readdata = {8'h0, bmux_cfg_ff};
      end else if (hit_aux) begin
        nxt_readdata = {8'h0, aux_cfg_ff};
      end else begin
        nxt_readdata = 32'h0;
      end
    end
    nxt_ecg_cfg = ecg_cfg_ff;
    nxt_bmux_cfg = bmux_cfg_ff;
    nxt_aux_cfg = aux_cfg_ff;
    if (commit) begin
      if (hit_ecg) begin
        nxt_ecg_cfg = be_merge(ecg_cfg_ff, avs_writedata,
                               avs_byteenable, `AFMC_ECG_MASK);
      end else if (hit_bmux) begin
        nxt_bmux_cfg = be_merge(bmux_cfg_ff, avs_writedata,
                                avs_byteenable, `AFMC_BMUX_MASK);
      end else if (hit_aux) begin
        nxt_aux_cfg = be_merge(aux_cfg_ff, avs_writedata,
                               avs_byteenable, `AFMC_AUX_MASK);
      end
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest_ff <= 1'b1;
      avs_readdata_ff <= 32'h0;
      ecg_cfg_ff <= `AFMC_ECG_RESET;
      bmux_cfg_ff <= `AFMC_BMUX_RESET;
      aux_cfg_ff <= `AFMC_AUX_RESET;
    end else begin
      avs_waitrequest_ff <= nxt_waitrequest;
      avs_readdata_ff <= nxt_readdata;
      ecg_cfg_ff <= nxt_ecg_cfg;
      bmux_cfg_ff <= nxt_bmux_cfg;
      aux_cfg_ff <= nxt_aux_cfg;
    end
  end

  // ****************************************************************
  // Next values of the control outputs.
  // ****************************************************************
  reg [1:0] nxt_ecg_lowpass_eff;
  reg [2:0] nxt_ecg_lowpass_cutoff;
  reg nxt_bioz_pos_input_connect;
  reg nxt_bioz_neg_input_connect;
  reg [2:0] nxt_bioz_pos_route;
  reg [2:0] nxt_bioz_neg_route;
  reg nxt_cg_chop;
  reg nxt_cg_lowpass;
  reg nxt_cg_resistive_cm;
  reg nxt_selftest_switch;
  reg [2:0] nxt_selftest_nominal_res;

  always @* begin
    nxt_ecg_lowpass_eff = lpf_eff;
    nxt_ecg_lowpass_cutoff = lpf_cut;
    nxt_bioz_pos_input_connect = ~bioz_pos_input_isolate;
    nxt_bioz_neg_input_connect = ~bioz_neg_input_isolate;
    nxt_bioz_pos_route = route_dec(bioz_pos_cal_route,
                                   cal_voltage_enable);
    nxt_bioz_neg_route = route_dec(bioz_neg_cal_route,
                                   cal_voltage_enable);
    nxt_cg_chop = 1'b0;
    nxt_cg_lowpass = 1'b0;
    nxt_cg_resistive_cm = 1'b0;
    case (current_gen_mode)
      2'h0: begin
        nxt_cg_lowpass = 1'b1;
      end
      2'h1: begin
        nxt_cg_chop = 1'b1;
      end
      2'h2: begin
        nxt_cg_chop = 1'b1;
        nxt_cg_lowpass = 1'b1;
      end
      default: begin
        nxt_cg_chop = 1'b1;
        nxt_cg_resistive_cm = 1'b1;
      end
    endcase
    nxt_selftest_switch = bist_active;
    nxt_selftest_nominal_res = selftest_nominal_res;
  end

  // ****************************************************************
  // Registered ECG filter outputs.
  // ****************************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ecg_lowpass_eff_ff <= 2'h0;
      ecg_lowpass_cutoff_ff <= `AFMC_CUT_BYPASS;
    end else begin
      ecg_lowpass_eff_ff <= nxt_ecg_lowpass_eff;
      ecg_lowpass_cutoff_ff <= nxt_ecg_lowpass_cutoff;
    end
  end

  // ****************************************************************
  // Registered bioimpedance control outputs.
  // ****************************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bioz_pos_input_connect_ff <= 1'b0;
      bioz_neg_input_connect_ff <= 1'b0;
      bioz_pos_route_ff <= 3'h0;
      bioz_neg_route_ff <= 3'h0;
      cg_chop_ff <= 1'b0;
      cg_lowpass_ff <= 1'b0;
      cg_resistive_cm_ff <= 1'b0;
      drive_outputs_isolate_ff <= 1'b0;
      drive_to_input_close_ff <= 1'b0;
      lead_bias_200m_ff <= 1'b0;
      selftest_nominal_res_ff <= 3'h0;
      modulation_switches_ff <= 3'h0;
    end else begin
      bioz_pos_input_connect_ff <= nxt_bioz_pos_input_connect;
      bioz_neg_input_connect_ff <= nxt_bioz_neg_input_connect;
      bioz_pos_route_ff <= nxt_bioz_pos_route;
      bioz_neg_route_ff <= nxt_bioz_neg_route;
      cg_chop_ff <= nxt_cg_chop;
      cg_lowpass_ff <= nxt_cg_lowpass;
      cg_resistive_cm_ff <= nxt_cg_resistive_cm;
      drive_outputs_isolate_ff <= nxt_selftest_switch;
      drive_to_input_close_ff <= nxt_selftest_switch;
      lead_bias_200m_ff <= nxt_selftest_switch;
      selftest_nominal_res_ff <= nxt_selftest_nominal_res;
      modulation_switches_ff <= nxt_mod_sw;
    end
  end

endmodule

// file: bench/afmc_top_asserts.sv
// Checker of port relations of the filter and input mux configuration block.
module afmc_chk (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Register bus
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata_ff,
  input wire avs_waitrequest_ff,
  // Decoded outputs
  input wire [1:0] ecg_lowpass_eff_ff,
  input wire [2:0] ecg_lowpass_cutoff_ff,
  input wire [2:0] bioz_pos_route_ff,
  input wire [2:0] bioz_neg_route_ff,
  input wire cg_chop_ff,
  input wire cg_lowpass_ff,
  input wire cg_resistive_cm_ff,
  input wire drive_outputs_isolate_ff,
  input wire drive_to_input_close_ff,
  input wire lead_bias_200m_ff,
  input wire [2:0] modulation_switches_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Properties.
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_ans;
    (avs_read || avs_write) && avs_waitrequest_ff |=> !avs_waitrequest_ff;
  endproperty
  a_ans: assert property (p_ans) else $error("bus not answered");
  property p_one;
    !avs_waitrequest_ff |=> avs_waitrequest_ff;
  endproperty
  a_one: assert property (p_one) else $error("wait low too long");
  property p_byp;
    (ecg_lowpass_eff_ff == 2'h0) == (ecg_lowpass_cutoff_ff == 3'h0);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass mismatch");
  property p_c100;
    ecg_lowpass_cutoff_ff == 3'h2 |-> ecg_lowpass_eff_ff == 2'h2;
  endproperty
  a_c100: assert property (p_c100) else $error("100 Hz code wrong");
  property p_c150;
    ecg_lowpass_cutoff_ff == 3'h3 |-> ecg_lowpass_eff_ff == 2'h3;
  endproperty
  a_c150: assert property (p_c150) else $error("150 Hz code wrong");
  property p_low;
    ecg_lowpass_cutoff_ff == 3'h4 |-> ecg_lowpass_eff_ff == 2'h1;
  endproperty
  a_low: assert property (p_low) else $error("low cutoff code wrong");
  property p_route;
    $onehot0(bioz_pos_route_ff) && $onehot0(bioz_neg_route_ff);
  endproperty
  a_route: assert property (p_route) else $error("route not one-hot");
  property p_cg;
    cg_resistive_cm_ff |-> cg_chop_ff && !cg_lowpass_ff;
  endproperty
  a_cg: assert property (p_cg) else $error("generator mode mix");
  property p_bist;
    drive_outputs_isolate_ff == drive_to_input_close_ff &&
      drive_to_input_close_ff == lead_bias_200m_ff;
  endproperty
  a_bist: assert property (p_bist) else $error("switches split");
  property p_mod;
    modulation_switches_ff != 3'h0 |->
      $onehot(modulation_switches_ff) && $past(drive_to_input_close_ff);
  endproperty
  a_mod: assert property (p_mod) else $error("stray modulation");
  property p_hi;
    avs_readdata_ff[31:24] == 8'h00;
  endproperty
  a_hi: assert property (p_hi) else $error("upper read byte set");
endmodule

bind afmc_top afmc_chk u_chk (.clk(clk), .resetn(resetn),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata_ff(avs_readdata_ff), .avs_waitrequest_ff(avs_waitrequest_ff),
  .ecg_lowpass_eff_ff(ecg_lowpass_eff_ff),
  .ecg_lowpass_cutoff_ff(ecg_lowpass_cutoff_ff),
  .bioz_pos_route_ff(bioz_pos_route_ff),
  .bioz_neg_route_ff(bioz_neg_route_ff),
  .cg_chop_ff(cg_chop_ff), .cg_lowpass_ff(cg_lowpass_ff),
  .cg_resistive_cm_ff(cg_resistive_cm_ff),
  .drive_outputs_isolate_ff(drive_outputs_isolate_ff),
  .drive_to_input_close_ff(drive_to_input_close_ff),
  .lead_bias_200m_ff(lead_bias_200m_ff),
  .modulation_switches_ff(modulation_switches_ff));

// file: bench/test_afmc_top.sv
// Self-checking bench of the filter and input mux configuration block.
module test_afmc_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Signals.
  // ****************************************************************
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hf;
  logic tick = 1'b0;
  wire [31:0] rdat;
  wire wreq;
  wire [1:0] eff;
  wire [2:0] cut, prt, nrt, rnom, mods;
  wire pcon, ncon, chop, lp, rcm, iso, cls, bias;
  int n_fail = 0;
  int comparisons = 0;
  afmc_top u_dut (.clk(clk), .resetn(resetn), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata_ff(rdat), .avs_waitrequest_ff(wreq), .mclk_tick(tick),
    .ecg_lowpass_eff_ff(eff), .ecg_lowpass_cutoff_ff(cut),
    .bioz_pos_input_connect_ff(pcon), .bioz_neg_input_connect_ff(ncon),
    .bioz_pos_route_ff(prt), .bioz_neg_route_ff(nrt), .cg_chop_ff(chop),
    .cg_lowpass_ff(lp), .cg_resistive_cm_ff(rcm),
    .drive_outputs_isolate_ff(iso), .drive_to_input_close_ff(cls),
    .lead_bias_200m_ff(bias), .selftest_nominal_res_ff(rnom),
    .modulation_switches_ff(mods));
  always #20 clk = ~clk;
  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task stop_test;
    begin
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
      comparisons++;
      if (g !== e) begin
        n_fail++;
        $display("BAD %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] m, output logic [31:0] q);
    int i;
    begin
      i = 0;
      adr <= a;
      wd <= d;
      be <= m;
      rd <= !w;
      wr <= w;
      @(posedge clk);
      while (wreq !== 1'b0) begin
        i++;
        if (i > 20) begin
          n_fail++;
          stop_test;
        end
        @(posedge clk);
      end
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task wrr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 4'hf, x);
  endtask
  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    begin
      bus(1'b0, a, 32'h0, 4'hf, x);
      chk(n, e, x);
    end
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task t_reset;
    begin
      wt(2);
      chk("eff", 32'h1, eff);
      chk("cut", 32'h4, cut);
      chk("pcon", 32'h0, pcon);
      chk("ncon", 32'h0, ncon);
      chk("mods", 32'h0, mods);
      rdc("ecg", 8'h54, 32'h801000);
      rdc("bmux", 8'h5c, 32'h300040);
      rdc("aux", 8'h7c, 32'h0);
      rdc("hole", 8'h60, 32'h0);
    end
  endtask
  task t_lpf;
    logic [1:0] e;
    logic [2:0] c;
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 4; k++) begin
        wrr(8'h54, {8'h0, r[1:0], 8'h0, k[1:0], 12'h0});
        for (int m = 0; m < 4; m++) begin
          e = 2'h1;
          c = 3'h1;
          if (k == 0) begin
            e = 2'h0;
            c = 3'h0;
          end else if (m < 2 && r == 2) begin
            c = 3'h4;
          end else if (m < 2 && r < 2 && k == 2) begin
            e = 2'h2;
            c = 3'h2;
          end else if (m < 2 && r == 0 && k == 3) begin
            e = 2'h3;
            c = 3'h3;
          end
          wrr(8'h7c, {30'h0, m[1:0]});
          wt(3);
          chk("eff", e, eff);
          chk("cut", c, cut);
          rdc("ecg", 8'h54, {8'h0, r[1:0], 8'h0, e, 12'h0});
        end
      end
    end
  endtask
  task t_mux;
    logic [2:0] rt;
    logic [31:0] x;
    begin
      bus(1'b1, 8'h5c, 32'hffffffff, 4'h1, x);
      rdc("lane", 8'h5c, 32'h300073);
      wrr(8'h5c, 32'hffffffff);
      rdc("bmux", 8'h5c, 32'h3f3f73);
      for (int v = 0; v < 2; v++) begin
        for (int i = 0; i < 4; i++) begin
          wrr(8'h7c, {28'h0, 1'b1, v[0], 2'h0});
          wrr(8'h5c, {10'h0, i[1:0], i[1:0], i[1:0], 2'h0, i[1:0],
            12'h0});
          wt(3);
          rt = (v == 0 || i == 0) ? 3'h0 : {i == 3, i == 2, 1'b0};
          if (i == 1) begin
            rt = 3'h1;
          end
          chk("pcon", !i[1], pcon);
          chk("ncon", !i[0], ncon);
          chk("prt", rt, prt);
          chk("nrt", rt, nrt);
          chk("cg", {i != 0, i == 0 || i == 2, i == 3},
            {chop, lp, rcm});
        end
      end
    end
  endtask
  task t_bist;
    begin
      wrr(8'h7c, 32'h4);
      wrr(8'h5c, 32'h300d00);
      wt(3);
      chk("bist", 32'h0, {iso, cls, bias});
      wrr(8'h7c, 32'h0);
      wt(3);
      chk("bist", 32'h7, {iso, cls, bias});
      chk("rnom", 32'h5, rnom);
      tick <= 1'b1;
      wt(2000);
      chk("mods", 32'h0, mods);
      wt(4000);
      chk("mods", 32'h1, mods);
      wrr(8'h5c, 32'h300d01);
      wt(4);
      chk("mods", 32'h0, mods);
      wrr(8'h5c, 32'h300d10);
      wt(4);
      chk("mods", 32'h2, mods);
      wrr(8'h5c, 32'h300d40);
      wt(4);
      chk("mods", 32'h0, mods);
      wrr(8'h5c, 32'h300d00);
      wrr(8'h7c, 32'h10);
      wt(4);
      chk("mods", 32'h0, mods);
      tick <= 1'b0;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_lpf;
    t_mux;
    t_bist;
    stop_test;
  end
endmodule
